// File: design/rac_defines.vh
`ifndef RAC_DEFINES_VH
`define RAC_DEFINES_VH

// address and range geometry
`define RAC_ADDR_W        32
`define RAC_NRANGE        8
`define RAC_NPAIR         4
`define RAC_NSET          4
`define RAC_SET_W         2
`define RAC_GRAN_BITS     3
`define RAC_NENTRY        32
`define RAC_IDX_W         5

// bound entry index fields: {code, pair[1:0], member, upper}
`define RAC_IDX_UPPER     0
`define RAC_IDX_MEMBER    1
`define RAC_IDX_PAIR_LSB  2
`define RAC_IDX_CODE      4

// access kinds
`define RAC_KIND_READ     2'h0
`define RAC_KIND_WRITE    2'h1
`define RAC_KIND_FETCH    2'h2

// packed set readback fields
`define RAC_SRD_DRS_LSB   0
`define RAC_SRD_RE_LSB    4
`define RAC_SRD_WE_LSB    12
`define RAC_SRD_XE_LSB    20
`define RAC_SRD_CRS_LSB   28

// reset values
`define RAC_BOUND_RST     29'h0000000
`define RAC_RS_RST        4'h0
`define RAC_PERM_RST      8'h00

`endif

// File: design/rac_bound_regs.v
`timescale 1ns/10ps
`default_nettype none
`include "rac_defines.vh"

// bound storage: all entries visible in parallel for the comparators,
// plus one registered readback port for software
module rac_bound_regs
(
  input  wire                                 clk,
  input  wire                                 rst_n,
  input  wire                                 wr_en,
  input  wire [`RAC_IDX_W-1:0]                wr_idx,
  input  wire [`RAC_ADDR_W-1:0]               wr_data,
  input  wire [`RAC_IDX_W-1:0]                rd_idx,
  output reg  [`RAC_ADDR_W-1:0]               rd_data_ff,
  output wire [`RAC_NENTRY*`RAC_ADDR_W-1:0]   bounds_flat
);

  wire [`RAC_NENTRY-1:0] wr_hit;

  // one-hot write select, so each entry sees a single enable bit
  assign wr_hit = wr_en ? ({{(`RAC_NENTRY-1){1'b0}}, 1'b1} << wr_idx) :
                          {`RAC_NENTRY{1'b0}};

  genvar e;
  generate
    for (e = 0; e < `RAC_NENTRY; e = e + 1)
    begin : g_ent
      reg  [`RAC_ADDR_W-1:`RAC_GRAN_BITS] bnd_ff;
      // only the upper bits are stored, so the low bits can never be set
      always @(posedge clk)
      begin
        if (!rst_n)
          bnd_ff <= `RAC_BOUND_RST;
        else if (wr_hit[e])
          bnd_ff <= wr_data[`RAC_ADDR_W-1:`RAC_GRAN_BITS];
      end
      assign bounds_flat[e*`RAC_ADDR_W +: `RAC_ADDR_W] =
        {bnd_ff, {`RAC_GRAN_BITS{1'b0}}};
    end
  endgenerate

  // registered readback of one entry
  always @(posedge clk)
  begin
    if (!rst_n)
      rd_data_ff <= {`RAC_ADDR_W{1'b0}};
    else
      rd_data_ff <= bounds_flat[rd_idx*`RAC_ADDR_W +: `RAC_ADDR_W];
  end

endmodule // rac_bound_regs

`default_nettype wire

// File: design/rac_range_access_checker.v
`timescale 1ns/10ps
`default_nettype none
`include "rac_defines.vh"

module rac_range_access_checker
(
  input  wire                     clk,
  input  wire                     rst_n,
  // system configuration and status word fields
  input  wire                     protection_enable_bit,
  input  wire [`RAC_SET_W-1:0]    current_set_number,
  // access request from the pipeline
  input  wire                     acc_valid,
  input  wire [1:0]               acc_kind,
  input  wire [`RAC_ADDR_W-1:0]   acc_addr,
  input  wire [2:0]               acc_last_off,
  input  wire                     acc_periph_space,
  input  wire                     acc_csa_xfer,
  // bound write and readback
  input  wire                     bnd_wr_en,
  input  wire [`RAC_IDX_W-1:0]    bnd_wr_idx,
  input  wire [`RAC_ADDR_W-1:0]   bnd_wr_data,
  input  wire [`RAC_IDX_W-1:0]    bnd_rd_idx,
  output wire [`RAC_ADDR_W-1:0]   bnd_rd_data_ff,
  // protection set configuration
  input  wire                     set_wr_en,
  input  wire [`RAC_SET_W-1:0]    set_idx,
  input  wire [`RAC_NPAIR-1:0]    set_data_range_select_flag,
  input  wire [`RAC_NRANGE-1:0]   set_read_permit_flag,
  input  wire [`RAC_NRANGE-1:0]   set_write_permit_flag,
  input  wire [`RAC_NPAIR-1:0]    set_code_range_select_flag,
  input  wire [`RAC_NRANGE-1:0]   set_execute_permit_flag,
  output reg  [31:0]              set_rd_data_ff,
  // verdict
  output reg                      acc_grant_ff,
  output reg                      read_violation_trap_ff,
  output reg                      write_violation_trap_ff,
  output reg                      execute_violation_trap_ff,
  output reg  [`RAC_ADDR_W-1:0]   trap_addr_ff
);

  // flags of all four sets laid side by side, set s at slice s
  wire [`RAC_NSET*`RAC_NPAIR-1:0]    drs_flat;
  wire [`RAC_NSET*`RAC_NRANGE-1:0]   re_flat;
  wire [`RAC_NSET*`RAC_NRANGE-1:0]   we_flat;
  wire [`RAC_NSET*`RAC_NPAIR-1:0]    crs_flat;
  wire [`RAC_NSET*`RAC_NRANGE-1:0]   xe_flat;
  wire [`RAC_NSET-1:0]               set_wr_hit;

  wire [`RAC_NENTRY*`RAC_ADDR_W-1:0] bounds_flat;
  wire [`RAC_ADDR_W-1:0]             addr_last;
  wire [`RAC_NPAIR-1:0]              cur_drs;
  wire [`RAC_NPAIR-1:0]              cur_crs;
  wire [`RAC_NRANGE-1:0]             cur_re;
  wire [`RAC_NRANGE-1:0]             cur_we;
  wire [`RAC_NRANGE-1:0]             cur_xe;
  wire [`RAC_NRANGE-1:0]             dsel;
  wire [`RAC_NRANGE-1:0]             csel;
  wire [`RAC_NRANGE-1:0]             dhit_a;
  wire [`RAC_NRANGE-1:0]             dhit_b;
  wire [`RAC_NRANGE-1:0]             chit_a;
  wire [`RAC_NRANGE-1:0]             chit_b;
  wire [`RAC_NRANGE-1:0]             rd_a;
  wire [`RAC_NRANGE-1:0]             rd_b;
  wire [`RAC_NRANGE-1:0]             wr_a;
  wire [`RAC_NRANGE-1:0]             wr_b;
  wire [`RAC_NRANGE-1:0]             ex_a;
  wire [`RAC_NRANGE-1:0]             ex_b;
  wire                               rd_ok;
  wire                               wr_ok;
  wire                               ex_ok;
  wire                               exempt;
  wire                               chk_on;

  reg                                nxt_grant;
  reg                                nxt_rtrap;
  reg                                nxt_wtrap;
  reg                                nxt_xtrap;
  reg  [`RAC_ADDR_W-1:0]             nxt_trap_addr;

  rac_bound_regs u_bounds
  (
    .clk         (clk),
    .rst_n       (rst_n),
    .wr_en       (bnd_wr_en),
    .wr_idx      (bnd_wr_idx),
    .wr_data     (bnd_wr_data),
    .rd_idx      (bnd_rd_idx),
    .rd_data_ff  (bnd_rd_data_ff),
    .bounds_flat (bounds_flat)
  );

  // one-hot write select; an idle write port touches no set
  assign set_wr_hit = set_wr_en ?
                      ({{(`RAC_NSET-1){1'b0}}, 1'b1} << set_idx) :
                      {`RAC_NSET{1'b0}};

  // set flag storage, one slice per set
  genvar s;
  generate
    for (s = 0; s < `RAC_NSET; s = s + 1)
    begin : g_set
      reg [`RAC_NPAIR-1:0]  drs_ff;
      reg [`RAC_NRANGE-1:0] re_ff;
      reg [`RAC_NRANGE-1:0] we_ff;
      reg [`RAC_NPAIR-1:0]  crs_ff;
      reg [`RAC_NRANGE-1:0] xe_ff;
      // sets are loaded whole so a set never mixes old and new flags
      always @(posedge clk)
      begin
        if (!rst_n)
        begin
          drs_ff <= `RAC_RS_RST;
          re_ff  <= `RAC_PERM_RST;
          we_ff  <= `RAC_PERM_RST;
          crs_ff <= `RAC_RS_RST;
          xe_ff  <= `RAC_PERM_RST;
        end
        else if (set_wr_hit[s])
        begin
          drs_ff <= set_data_range_select_flag;
          re_ff  <= set_read_permit_flag;
          we_ff  <= set_write_permit_flag;
          crs_ff <= set_code_range_select_flag;
          xe_ff  <= set_execute_permit_flag;
        end
      end
      // expose this set beside the others for the selection muxes
      assign drs_flat[s*`RAC_NPAIR +: `RAC_NPAIR]   = drs_ff;
      assign re_flat[s*`RAC_NRANGE +: `RAC_NRANGE]  = re_ff;
      assign we_flat[s*`RAC_NRANGE +: `RAC_NRANGE]  = we_ff;
      assign crs_flat[s*`RAC_NPAIR +: `RAC_NPAIR]   = crs_ff;
      assign xe_flat[s*`RAC_NRANGE +: `RAC_NRANGE]  = xe_ff;
    end
  endgenerate

  // readback of the set addressed by set_idx
  always @(posedge clk)
  begin
    if (!rst_n)
      set_rd_data_ff <= 32'h00000000;
    else
    begin
      set_rd_data_ff <= 32'h00000000;
      set_rd_data_ff[`RAC_SRD_DRS_LSB +: `RAC_NPAIR]  <=
        drs_flat[set_idx*`RAC_NPAIR +: `RAC_NPAIR];
      set_rd_data_ff[`RAC_SRD_RE_LSB  +: `RAC_NRANGE] <=
        re_flat[set_idx*`RAC_NRANGE +: `RAC_NRANGE];
      set_rd_data_ff[`RAC_SRD_WE_LSB  +: `RAC_NRANGE] <=
        we_flat[set_idx*`RAC_NRANGE +: `RAC_NRANGE];
      set_rd_data_ff[`RAC_SRD_XE_LSB  +: `RAC_NRANGE] <=
        xe_flat[set_idx*`RAC_NRANGE +: `RAC_NRANGE];
      set_rd_data_ff[`RAC_SRD_CRS_LSB +: `RAC_NPAIR]  <=
        crs_flat[set_idx*`RAC_NPAIR +: `RAC_NPAIR];
    end
  end

  // the governing set is the one named by the status word
  assign cur_drs =
    drs_flat[current_set_number*`RAC_NPAIR +: `RAC_NPAIR];
  assign cur_crs =
    crs_flat[current_set_number*`RAC_NPAIR +: `RAC_NPAIR];
  assign cur_re  =
    re_flat[current_set_number*`RAC_NRANGE +: `RAC_NRANGE];
  assign cur_we  =
    we_flat[current_set_number*`RAC_NRANGE +: `RAC_NRANGE];
  assign cur_xe  =
    xe_flat[current_set_number*`RAC_NRANGE +: `RAC_NRANGE];

  // last byte of the access; a wrap past the top is accepted as is
  assign addr_last = acc_addr + {{(`RAC_ADDR_W-3){1'b0}}, acc_last_off};

  // per-range select and hit; range g is member g[0] of pair g>>1
  genvar g;
  generate
    for (g = 0; g < `RAC_NRANGE; g = g + 1)
    begin : g_rng
      localparam       MEMB = g % 2;
      localparam       PAIR = g / 2;
      localparam       DLO  = 2 * g;
      localparam       CLO  = `RAC_NENTRY / 2 + 2 * g;
      wire [`RAC_ADDR_W-1:0] dlo;
      wire [`RAC_ADDR_W-1:0] dhi;
      wire [`RAC_ADDR_W-1:0] clo;
      wire [`RAC_ADDR_W-1:0] chi;
      // each member owns a lower and an upper bound entry
      assign dlo = bounds_flat[DLO*`RAC_ADDR_W +: `RAC_ADDR_W];
      assign dhi = bounds_flat[(DLO+1)*`RAC_ADDR_W +: `RAC_ADDR_W];
      assign clo = bounds_flat[CLO*`RAC_ADDR_W +: `RAC_ADDR_W];
      assign chi = bounds_flat[(CLO+1)*`RAC_ADDR_W +: `RAC_ADDR_W];
      // one select flag per pair chooses one member into the set
      assign dsel[g] = cur_drs[PAIR] ^ (MEMB == 0);
      assign csel[g] = cur_crs[PAIR] ^ (MEMB == 0);
      // upper bound is exclusive
      assign dhit_a[g] = (acc_addr  >= dlo) && (acc_addr  < dhi);
      assign dhit_b[g] = (addr_last >= dlo) && (addr_last < dhi);
      assign chit_a[g] = (acc_addr  >= clo) && (acc_addr  < chi);
      assign chit_b[g] = (addr_last >= clo) && (addr_last < chi);
      // a range counts only if selected, covering and permitting
      assign rd_a[g] = dsel[g] & dhit_a[g] & cur_re[g];
      assign rd_b[g] = dsel[g] & dhit_b[g] & cur_re[g];
      assign wr_a[g] = dsel[g] & dhit_a[g] & cur_we[g];
      assign wr_b[g] = dsel[g] & dhit_b[g] & cur_we[g];
      assign ex_a[g] = csel[g] & chit_a[g] & cur_xe[g];
      assign ex_b[g] = csel[g] & chit_b[g] & cur_xe[g];
    end
  endgenerate

  // OR over all selected covering ranges; both end bytes must pass,
  // so a straddle into a forbidden region always traps
  assign rd_ok = (|rd_a) && (|rd_b);
  assign wr_ok = (|wr_a) && (|wr_b);
  // fetch sees code ranges only, data ranges never enter here
  assign ex_ok = (|ex_a) && (|ex_b);

  // exempt spaces and context traffic skip the ranges entirely
  assign exempt = acc_periph_space || acc_csa_xfer;

  // no privilege term: supervisor is judged like any user task
  assign chk_on = protection_enable_bit && !exempt;

  // verdict; kind 3 is no request and gets neither grant nor trap
  always @*
  begin
    nxt_grant     = 1'b0;
    nxt_rtrap     = 1'b0;
    nxt_wtrap     = 1'b0;
    nxt_xtrap     = 1'b0;
    nxt_trap_addr = trap_addr_ff;
    if (acc_valid)
    begin
      case (acc_kind)
        `RAC_KIND_READ:
        begin
          nxt_grant = !chk_on || rd_ok;
          nxt_rtrap = chk_on && !rd_ok;
        end
        `RAC_KIND_WRITE:
        begin
          nxt_grant = !chk_on || wr_ok;
          nxt_wtrap = chk_on && !wr_ok;
        end
        `RAC_KIND_FETCH:
        begin
          nxt_grant = !chk_on || ex_ok;
          nxt_xtrap = chk_on && !ex_ok;
        end
        default:
        begin
          nxt_grant = 1'b0;
        end
      endcase
      // the denied address is kept until the next denial for the handler
      if (nxt_rtrap || nxt_wtrap || nxt_xtrap)
        nxt_trap_addr = acc_addr;
    end
  end

  // verdict registers: one-cycle pulses one edge after the request
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      acc_grant_ff              <= 1'b0;
      read_violation_trap_ff    <= 1'b0;
      write_violation_trap_ff   <= 1'b0;
      execute_violation_trap_ff <= 1'b0;
      trap_addr_ff              <= {`RAC_ADDR_W{1'b0}};
    end
    else
    begin
      acc_grant_ff              <= nxt_grant;
      read_violation_trap_ff    <= nxt_rtrap;
      write_violation_trap_ff   <= nxt_wtrap;
      execute_violation_trap_ff <= nxt_xtrap;
      trap_addr_ff              <= nxt_trap_addr;
    end
  end

endmodule // rac_range_access_checker

`default_nettype wire

// File: test/rac_pipe_model.sv
`timescale 1ns/10ps
`default_nettype none
// core pipeline side: one load, store or fetch per call
module rac_pipe_model
(
  input  wire logic        clk,
  output logic             acc_valid,
  output logic [1:0]       acc_kind,
  output logic [31:0]      acc_addr,
  output logic [2:0]       acc_last_off,
  output logic             acc_periph_space,
  output logic             acc_csa_xfer
);
  // idle at time zero so no request leaks into reset
  initial
  begin
    acc_valid = 1'b0;
    {acc_kind, acc_addr, acc_last_off} = 37'h0;
    {acc_periph_space, acc_csa_xfer} = 2'h0;
  end
  // launch after a falling edge, hold across the taking edge
  task issue(input logic [1:0] k, input logic [31:0] a,
             input logic [2:0] o, input logic p, input logic c);
  begin
    @(negedge clk);
    {acc_valid, acc_kind, acc_addr} = {1'b1, k, a};
    {acc_last_off, acc_periph_space, acc_csa_xfer} = {o, p, c};
    @(posedge clk);
    @(negedge clk);
    // released lines show junk, never the last request
    {acc_valid, acc_kind, acc_addr} = {1'b0, ~k, ~a};
    {acc_last_off, acc_periph_space, acc_csa_xfer} = {~o, ~p, ~c};
  end
  endtask
endmodule // rac_pipe_model
`default_nettype wire

// File: test/rac_range_access_checker_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module rac_chk
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire        protection_enable_bit,
  input  wire        acc_valid,
  input  wire [1:0]  acc_kind,
  input  wire [31:0] acc_addr,
  input  wire        acc_periph_space,
  input  wire        acc_csa_xfer,
  input  wire [31:0] bnd_rd_data_ff,
  input  wire        acc_grant_ff,
  input  wire        read_violation_trap_ff,
  input  wire        write_violation_trap_ff,
  input  wire        execute_violation_trap_ff,
  input  wire [31:0] trap_addr_ff
);
  // verdict vector {grant, read, write, fetch}; kind 3 is no request
  wire [3:0] vd = {acc_grant_ff, read_violation_trap_ff,
                   write_violation_trap_ff, execute_violation_trap_ff};
  wire       req = acc_valid && (acc_kind != 2'h3);
  wire       trp = |vd[2:0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_ONE: assert property (req |=> $onehot(vd))
    else $error("request without exactly one verdict");
  AST_NONE: assert property (!req |=> vd == 4'h0)
    else $error("verdict without request");
  AST_OFF: assert property (req && !protection_enable_bit |=> vd == 4'h8)
    else $error("denied while checking off");
  AST_PER: assert property (req && acc_periph_space |=> acc_grant_ff)
    else $error("peripheral space access denied");
  AST_CSA: assert property (req && acc_csa_xfer |=> acc_grant_ff)
    else $error("context transfer denied");
  AST_KIND: assert property (trp |-> vd[2:0] == (3'h4 >> $past(acc_kind)))
    else $error("trap does not match access kind");
  AST_TADDR: assert property (trp |-> trap_addr_ff == $past(acc_addr))
    else $error("trap address not captured");
  AST_THOLD: assert property ($past(rst_n) && !trp |-> $stable(trap_addr_ff))
    else $error("trap address moved without trap");
  AST_GRAN: assert property (bnd_rd_data_ff[2:0] == 3'h0)
    else $error("bound low bits not zero");
  // main scenarios reached
  cover property (req && protection_enable_bit ##1 read_violation_trap_ff);
  cover property (req ##1 write_violation_trap_ff);
  cover property (req ##1 execute_violation_trap_ff);
endmodule // rac_chk
bind rac_range_access_checker rac_chk u_chk (.clk, .rst_n,
  .protection_enable_bit, .acc_valid, .acc_kind, .acc_addr,
  .acc_periph_space, .acc_csa_xfer, .bnd_rd_data_ff, .acc_grant_ff,
  .read_violation_trap_ff, .write_violation_trap_ff,
  .execute_violation_trap_ff, .trap_addr_ff);
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk, rst_n, protection_enable_bit, bnd_wr_en, set_wr_en;
  logic [1:0]  current_set_number, set_idx;
  logic [4:0]  bnd_wr_idx, bnd_rd_idx;
  logic [31:0] bnd_wr_data;
  logic [3:0]  set_data_range_select_flag, set_code_range_select_flag;
  logic [7:0]  set_read_permit_flag, set_write_permit_flag;
  logic [7:0]  set_execute_permit_flag;
  wire         acc_valid, acc_periph_space, acc_csa_xfer, acc_grant_ff;
  wire  [1:0]  acc_kind;
  wire  [2:0]  acc_last_off;
  wire  [31:0] acc_addr, bnd_rd_data_ff, set_rd_data_ff, trap_addr_ff;
  wire         read_violation_trap_ff, write_violation_trap_ff;
  wire         execute_violation_trap_ff;
  int          error_cnt = 0, checks = 0, cyc = 0;
  rac_pipe_model pipe (.clk, .acc_valid, .acc_kind, .acc_addr,
    .acc_last_off, .acc_periph_space, .acc_csa_xfer);
  rac_range_access_checker DUT (.clk, .rst_n, .protection_enable_bit,
    .current_set_number, .acc_valid, .acc_kind, .acc_addr, .acc_last_off,
    .acc_periph_space, .acc_csa_xfer, .bnd_wr_en, .bnd_wr_idx,
    .bnd_wr_data, .bnd_rd_idx, .bnd_rd_data_ff, .set_wr_en, .set_idx,
    .set_data_range_select_flag, .set_read_permit_flag,
    .set_write_permit_flag, .set_code_range_select_flag,
    .set_execute_permit_flag, .set_rd_data_ff, .acc_grant_ff,
    .read_violation_trap_ff, .write_violation_trap_ff,
    .execute_violation_trap_ff, .trap_addr_ff);
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task end_of_test;
  begin
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  // hang guard: the whole run needs about eighty cycles
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      error_cnt = error_cnt + 1;
      end_of_test();
    end
  end
  task cmp(input string n, input logic [31:0] s, input logic [31:0] e);
  begin
    checks = checks + 1;
    if (s !== e)
    begin
      error_cnt = error_cnt + 1;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  end
  endtask
  task wb(input logic [4:0] i, input logic [31:0] d);
  begin
    @(negedge clk);
    {bnd_wr_en, bnd_wr_idx, bnd_wr_data} = {1'b1, i, d};
    @(negedge clk);
    bnd_wr_en = 1'b0;
  end
  endtask
  task ws(input logic [1:0] s, input logic [31:0] f);
  begin
    @(negedge clk);
    {set_wr_en, set_idx} = {1'b1, s};
    {set_code_range_select_flag, set_execute_permit_flag} = f[31:20];
    {set_write_permit_flag, set_read_permit_flag} = f[19:4];
    set_data_range_select_flag = f[3:0];
    @(negedge clk);
    set_wr_en = 1'b0;
  end
  endtask
  // e is {grant, read, write, fetch}; a trap also latches the address
  task chk(input logic [1:0] k, input logic [31:0] a, input logic [2:0] o,
           input logic [1:0] pc, input logic [3:0] e);
  begin
    pipe.issue(k, a, o, pc[1], pc[0]);
    cmp("verdict", {acc_grant_ff, read_violation_trap_ff,
        write_violation_trap_ff, execute_violation_trap_ff}, e);
    if (e[2:0] != 3'h0)
      cmp("trap_addr", trap_addr_ff, a);
  end
  endtask
  task t_cfg;
  begin
    cmp("reset_bound", bnd_rd_data_ff, 32'h0);
    cmp("reset_set", set_rd_data_ff, 32'h0);
    cmp("reset_taddr", trap_addr_ff, 32'h0);
    cmp("reset_verdict", {acc_grant_ff, read_violation_trap_ff,
        write_violation_trap_ff, execute_violation_trap_ff}, 32'h0);
    wb(5'h00, 32'h1007);
    wb(5'h01, 32'h2005);
    wb(5'h02, 32'h3000);
    wb(5'h03, 32'h4000);
    wb(5'h04, 32'h1000);
    wb(5'h05, 32'h1800);
    wb(5'h10, 32'h8000);
    wb(5'h11, 32'h9000);
    @(negedge clk) bnd_rd_idx = 5'h00;
    @(negedge clk) cmp("bound0", bnd_rd_data_ff, 32'h1000);
    bnd_rd_idx = 5'h01;
    @(negedge clk) cmp("bound1", bnd_rd_data_ff, 32'h2000);
    ws(2'h1, 32'h0010_4050);
    ws(2'h2, 32'h0000_2021);
    @(negedge clk) set_idx = 2'h1;
    @(negedge clk) cmp("set1", set_rd_data_ff, 32'h0010_4050);
    $display("test config done");
  end
  endtask
  task t_off;
  begin
    current_set_number = 2'h3;
    chk(2'h1, 32'h5000, 3'h0, 2'h0, 4'h8);
    protection_enable_bit = 1'b1;
    chk(2'h1, 32'h5000, 3'h0, 2'h0, 4'h2);
    $display("test enable done");
  end
  endtask
  task t_set1;
  begin
    current_set_number = 2'h1;
    chk(2'h0, 32'h1000, 3'h0, 2'h0, 4'h8);
    chk(2'h0, 32'h1FF8, 3'h7, 2'h0, 4'h8);
    chk(2'h0, 32'h2000, 3'h0, 2'h0, 4'h4);
    chk(2'h0, 32'h3000, 3'h0, 2'h0, 4'h4);
    chk(2'h2, 32'h1000, 3'h0, 2'h0, 4'h1);
    chk(2'h0, 32'h8000, 3'h0, 2'h0, 4'h4);
    chk(2'h2, 32'h8000, 3'h3, 2'h0, 4'h8);
    chk(2'h1, 32'h1100, 3'h3, 2'h0, 4'h8);
    chk(2'h1, 32'h1900, 3'h0, 2'h0, 4'h2);
    chk(2'h0, 32'h1FFC, 3'h7, 2'h0, 4'h4);
    chk(2'h3, 32'h1000, 3'h0, 2'h0, 4'h0);
    $display("test set one done");
  end
  endtask
  task t_sel;
  begin
    current_set_number = 2'h2;
    chk(2'h0, 32'h3000, 3'h0, 2'h0, 4'h8);
    chk(2'h1, 32'h3FF8, 3'h7, 2'h0, 4'h8);
    chk(2'h0, 32'h1000, 3'h0, 2'h0, 4'h4);
    chk(2'h2, 32'h8000, 3'h0, 2'h0, 4'h1);
    current_set_number = 2'h3;
    chk(2'h0, 32'h1000, 3'h0, 2'h0, 4'h4);
    chk(2'h1, 32'h1000, 3'h0, 2'h2, 4'h8);
    chk(2'h0, 32'h1000, 3'h0, 2'h1, 4'h8);
    // set 3 picks the second member of code pair 0
    wb(5'h12, 32'hA000);
    wb(5'h13, 32'hB000);
    ws(2'h3, 32'h1020_0000);
    chk(2'h2, 32'hA000, 3'h7, 2'h0, 4'h8);
    chk(2'h2, 32'h8000, 3'h0, 2'h0, 4'h1);
    $display("test selection done");
  end
  endtask
  initial
  begin
    {rst_n, protection_enable_bit, current_set_number} = 4'h0;
    {bnd_wr_en, bnd_wr_idx, bnd_wr_data, bnd_rd_idx} = 43'h0;
    {set_wr_en, set_idx, set_data_range_select_flag} = 7'h0;
    {set_read_permit_flag, set_write_permit_flag} = 16'h0;
    {set_code_range_select_flag, set_execute_permit_flag} = 12'h0;
    repeat (2) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    t_cfg();
    t_off();
    t_set1();
    t_sel();
    end_of_test();
  end
endmodule // tb
`default_nettype wire
